// file: include/uart_bsi_regs.vh
// register offsets, fields, reset values and timing counts for the uart buffer block
`ifndef UART_BSI_REGS_VH
`define UART_BSI_REGS_VH
`define ADDR_RX_DATA 12'h14c
`define ADDR_CMD 12'h148
`define ADDR_TX_DATA 12'h14c
`define ADDR_CHANNEL_STATUS 12'h144
`define ADDR_MODE_ONE 12'h140
`define ADDR_IN_CHANGE 12'h150
`define ADDR_AUX_CTRL 12'h150
`define ADDR_INT_FLAGS 12'h154
`define ADDR_INT_ENABLES 12'h154
`define ADDR_BAUD_HIGH 12'h158
`define ADDR_BAUD_LOW 12'h15c
`define ADDR_VECTOR 12'h170
`define ADDR_PIN_LEVEL 12'h174
`define ADDR_OUT_SET 12'h178
`define ADDR_OUT_CLEAR 12'h17c
`define ADDR_CONFIG 12'h180
`define RX_DATA_RESET 8'hff
`define VECTOR_RESET 8'h0f
`define BAUD_MIN 16'h0002
`define INT_TX_READY 0
`define INT_RX 1
`define INT_BREAK 2
`define INT_CHANGE 7
`define MODE_ONE_RX_SEL 6
`define AUX_CHANGE_EN 0
`define CFG_LOOPBACK 0
`define CFG_MULTIDROP 1
`define CMD_RX_NONE 2'h0
`define CMD_RX_ENABLE 2'h1
`define CMD_RX_DISABLE 2'h2
`define CMD_TX_NONE 2'h0
`define CMD_TX_ENABLE 2'h1
`define CMD_TX_DISABLE 2'h2
`define CMD_MISC_RESET_RX 3'h2
`define CMD_MISC_RESET_TX 3'h3
`define CMD_MISC_RESET_BREAK 3'h5
`define CTS_FILTER_NS 25000
`define CLK_PERIOD_NS 5
`define CTS_FILTER_CYCLES ((`CTS_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// file: core/uart_buffers_status.v
// uart receive fifo, transmit buffer, cts change and interrupt status logic
`timescale 1ns/1ps
`default_nettype none
`include "uart_bsi_regs.vh"
module uart_buffers_status #(
  parameter FILTER_CYCLES = `CTS_FILTER_CYCLES,
  parameter FIFO_DEPTH = 3,
  parameter STARTUP_TICKS = 2
) (
  // clock, reset, enable
  input wire clk,
  input wire rst,
  input wire clkEn,
  // register port
  input wire [11:0] addr,
  input wire [7:0] wrData,
  input wire wrStb,
  input wire rdStb,
  output reg [7:0] rdData,
  // receive shifter side
  input wire rxCharDone,
  input wire [7:0] rxChar,
  input wire rxBreakEdge,
  output wire rxEnabled,
  output wire rxHunt,
  // transmit shifter side
  input wire txShiftEmpty,
  output reg txLoad,
  output reg [7:0] txChar,
  output wire txEnabled,
  // baud timer
  input wire serialTick,
  output wire [15:0] baudPreload,
  // pins
  input wire ctsPinN,
  output reg rtsPinN,
  // interrupt
  output wire intReq,
  output wire [7:0] intVector
);
  localparam CNT_W = 16;
  localparam [15:0] BAUD_RESET = `BAUD_MIN;
  // receive fifo storage
  reg [7:0] fifoMem [0:FIFO_DEPTH-1];
  reg [1:0] fifoCount_reg;
  reg rxEnable_reg;
  reg rxHunt_reg;
  reg txEnable_reg;
  reg txReady_reg;
  reg [7:0] txHold_reg;
  reg [7:0] modeOne_reg;
  reg [1:0] config_reg;
  reg [7:0] auxCtrl_reg;
  reg [7:0] intEnables_reg;
  reg [7:0] vector_reg;
  reg [7:0] baudHigh_reg;
  reg [7:0] baudLow_reg;
  reg breakChange_reg;
  reg changeFlag_reg;
  reg changeStatus_reg;
  reg rtsBit_reg;
  // cts synchroniser and filter
  reg ctsMeta_reg;
  reg ctsSync_reg;
  reg ctsStable_reg;
  reg [CNT_W-1:0] filterCnt_reg;
  reg [1:0] startTicks_reg;
  reg ctsLive_reg;
  wire fifoFull;
  wire fifoEmpty;
  wire rxActive;
  wire popFifo;
  wire pushFifo;
  wire readChange;
  wire cmdWrite;
  wire [1:0] rxCmd;
  wire [1:0] txCmd;
  wire [2:0] miscCmd;
  wire ctsChangeEvent;
  wire [7:0] intFlags;
  wire wrModeOne;
  wire wrConfig;
  wire wrAuxCtrl;
  wire wrIntEnables;
  wire wrVector;
  wire wrBaudHigh;
  wire wrBaudLow;
  wire wrOutSet;
  wire wrOutClear;
  wire wrTxData;
  wire resetRx;
  wire resetTx;
  wire resetBreak;
  wire startupSample;
  wire startupChange;
  integer i;

  function isWrite;
    input [11:0] a;
    input [11:0] target;
    begin
      isWrite = wrStb && (a == target);
    end
  endfunction

  assign fifoFull = (fifoCount_reg == FIFO_DEPTH);
  assign fifoEmpty = (fifoCount_reg == 2'd0);
  assign rxActive = rxEnable_reg || config_reg[`CFG_LOOPBACK] || config_reg[`CFG_MULTIDROP];
  assign rxEnabled = rxActive;
  assign rxHunt = rxHunt_reg;
  assign txEnabled = txEnable_reg;
  assign popFifo = rdStb && (addr == `ADDR_RX_DATA) && !fifoEmpty;
  assign pushFifo = rxCharDone && rxActive && !fifoFull;
  assign readChange = rdStb && (addr == `ADDR_IN_CHANGE);
  assign cmdWrite = isWrite(addr, `ADDR_CMD);
  assign wrModeOne = isWrite(addr, `ADDR_MODE_ONE);
  assign wrConfig = isWrite(addr, `ADDR_CONFIG);
  assign wrAuxCtrl = isWrite(addr, `ADDR_AUX_CTRL);
  assign wrIntEnables = isWrite(addr, `ADDR_INT_ENABLES);
  assign wrVector = isWrite(addr, `ADDR_VECTOR);
  assign wrBaudHigh = isWrite(addr, `ADDR_BAUD_HIGH);
  assign wrBaudLow = isWrite(addr, `ADDR_BAUD_LOW);
  assign wrOutSet = isWrite(addr, `ADDR_OUT_SET);
  assign wrOutClear = isWrite(addr, `ADDR_OUT_CLEAR);
  assign wrTxData = isWrite(addr, `ADDR_TX_DATA);
  assign resetRx = cmdWrite && (miscCmd == `CMD_MISC_RESET_RX);
  assign resetTx = cmdWrite && (miscCmd == `CMD_MISC_RESET_TX);
  assign resetBreak = cmdWrite && (miscCmd == `CMD_MISC_RESET_BREAK);
  assign startupSample = !ctsLive_reg && (startTicks_reg == STARTUP_TICKS[1:0]);
  assign startupChange = startupSample && !ctsSync_reg;
  assign rxCmd = wrData[1:0];
  assign txCmd = wrData[3:2];
  assign miscCmd = wrData[6:4];
  assign baudPreload = {baudHigh_reg, baudLow_reg};
  assign intVector = vector_reg;
  assign ctsChangeEvent = ctsLive_reg && (ctsSync_reg != ctsStable_reg) &&
    (filterCnt_reg == FILTER_CYCLES[CNT_W-1:0]);
  // status bits: change, break, receiver, transmitter
  assign intFlags = {changeStatus_reg, 4'h0, breakChange_reg,
    (modeOne_reg[`MODE_ONE_RX_SEL] ? fifoFull : !fifoEmpty),
    txReady_reg};
  assign intReq = |(intFlags & intEnables_reg);

  // receiver control and fifo
  always @(posedge clk) begin
    if (rst) begin
      fifoCount_reg <= 2'd0;
      rxEnable_reg <= 1'b0;
      rxHunt_reg <= 1'b0;
      breakChange_reg <= 1'b0;
      for (i = 0; i < FIFO_DEPTH; i = i + 1) begin
        fifoMem[i] <= `RX_DATA_RESET;
      end
    end else if (clkEn) begin
      if (rxCharDone && rxActive) begin
        rxHunt_reg <= 1'b0;
      end
      if (cmdWrite) begin
        case (rxCmd)
          `CMD_RX_ENABLE: begin
            if (!rxEnable_reg) begin
              rxEnable_reg <= 1'b1;
              rxHunt_reg <= !config_reg[`CFG_MULTIDROP];
            end
          end
          `CMD_RX_DISABLE: begin
            rxEnable_reg <= 1'b0;
            if (!(config_reg[`CFG_LOOPBACK] || config_reg[`CFG_MULTIDROP])) begin
              rxHunt_reg <= 1'b0;
            end
          end
          default: begin
            rxEnable_reg <= rxEnable_reg;
          end
        endcase
        if (resetRx) begin
          rxEnable_reg <= 1'b0;
          rxHunt_reg <= 1'b0;
        end
      end
      // shift down on pop, write pushed char at the new tail
      if (popFifo) begin
        for (i = 0; i < FIFO_DEPTH - 1; i = i + 1) begin
          fifoMem[i] <= fifoMem[i+1];
        end
      end
      if (pushFifo || (popFifo && rxCharDone && rxActive)) begin
        fifoMem[popFifo ? fifoCount_reg - 2'd1 : fifoCount_reg] <= rxChar;
      end
      if (resetRx) begin
        fifoCount_reg <= 2'd0;
      end else if (popFifo && !(rxCharDone && rxActive)) begin
        fifoCount_reg <= fifoCount_reg - 2'd1;
      end else if (pushFifo && !popFifo) begin
        fifoCount_reg <= fifoCount_reg + 2'd1;
      end
      if (rxBreakEdge) begin
        breakChange_reg <= 1'b1;
      end else if (resetBreak) begin
        breakChange_reg <= 1'b0;
      end
    end
  end

  // transmitter holding register
  always @(posedge clk) begin
    if (rst) begin
      txEnable_reg <= 1'b0;
      txReady_reg <= 1'b0;
      txHold_reg <= 8'h00;
      txLoad <= 1'b0;
      txChar <= 8'h00;
    end else if (clkEn) begin
      txLoad <= 1'b0;
      if (resetTx || (cmdWrite && txCmd == `CMD_TX_DISABLE)) begin
        txEnable_reg <= 1'b0;
        txReady_reg <= 1'b0;
      end else if (cmdWrite && txCmd == `CMD_TX_ENABLE && !txEnable_reg) begin
        txEnable_reg <= 1'b1;
        txReady_reg <= 1'b1;
      end else if (wrTxData && txReady_reg && txEnable_reg) begin
        txHold_reg <= wrData;
        txReady_reg <= 1'b0;
      end else if (txEnable_reg && !txReady_reg && txShiftEmpty && !txLoad) begin
        txChar <= txHold_reg;
        txLoad <= 1'b1;
        txReady_reg <= 1'b1;
      end
    end
  end

  // configuration registers
  always @(posedge clk) begin
    if (rst) begin
      modeOne_reg <= 8'h00;
      config_reg <= 2'h0;
      auxCtrl_reg <= 8'h00;
      intEnables_reg <= 8'h00;
      vector_reg <= `VECTOR_RESET;
      baudHigh_reg <= BAUD_RESET[15:8];
      baudLow_reg <= BAUD_RESET[7:0];
      rtsBit_reg <= 1'b0;
      rtsPinN <= 1'b1;
    end else if (clkEn) begin
      if (wrModeOne) begin
        modeOne_reg <= wrData;
      end
      if (wrConfig) begin
        config_reg <= wrData[1:0];
      end
      if (wrAuxCtrl) begin
        auxCtrl_reg <= wrData;
      end
      if (wrIntEnables) begin
        intEnables_reg <= wrData;
      end
      if (wrVector) begin
        vector_reg <= wrData;
      end
      if (wrBaudHigh) begin
        baudHigh_reg <= wrData;
      end
      if (wrBaudLow) begin
        baudLow_reg <= wrData;
      end
      if (wrOutSet && wrData[0]) begin
        rtsBit_reg <= 1'b1;
        rtsPinN <= 1'b0;
      end else if (wrOutClear && wrData[0]) begin
        rtsBit_reg <= 1'b0;
        rtsPinN <= 1'b1;
      end
    end
  end

  // cts sampling, filter and change flags
  always @(posedge clk) begin
    if (rst) begin
      ctsMeta_reg <= 1'b1;
      ctsSync_reg <= 1'b1;
      ctsStable_reg <= 1'b1;
      filterCnt_reg <= {CNT_W{1'b0}};
      startTicks_reg <= 2'd0;
      ctsLive_reg <= 1'b0;
      changeFlag_reg <= 1'b0;
      changeStatus_reg <= 1'b0;
    end else if (clkEn) begin
      ctsMeta_reg <= ctsPinN;
      ctsSync_reg <= ctsMeta_reg;
      if (!ctsLive_reg) begin
        if (serialTick) startTicks_reg <= startTicks_reg + 2'd1;
        if (startupSample) begin
          ctsLive_reg <= 1'b1;
          ctsStable_reg <= ctsSync_reg;
          if (startupChange) begin
            changeFlag_reg <= 1'b1;
            if (auxCtrl_reg[`AUX_CHANGE_EN]) changeStatus_reg <= 1'b1;
          end
        end
      end else if (ctsSync_reg == ctsStable_reg) begin
        filterCnt_reg <= {CNT_W{1'b0}};
      end else if (ctsChangeEvent) begin
        ctsStable_reg <= ctsSync_reg;
        filterCnt_reg <= {CNT_W{1'b0}};
      end else begin
        filterCnt_reg <= filterCnt_reg + 1'b1;
      end
      if (ctsChangeEvent) begin
        changeFlag_reg <= 1'b1;
        if (auxCtrl_reg[`AUX_CHANGE_EN]) changeStatus_reg <= 1'b1;
      end else if (readChange && !startupChange) begin
        changeFlag_reg <= 1'b0;
        changeStatus_reg <= 1'b0;
      end
    end
  end

  // read data, valid in the cycle after the strobe
  always @(posedge clk) begin
    if (rst) begin
      rdData <= 8'h00;
    end else if (clkEn) begin
      rdData <= 8'h00;
      if (rdStb) begin
        case (addr)
          `ADDR_RX_DATA: rdData <= fifoMem[0];
          `ADDR_CHANNEL_STATUS: rdData <= {6'h00, fifoFull, !fifoEmpty} |
            {5'h00, txReady_reg, 2'h0};
          `ADDR_IN_CHANGE: rdData <= {changeFlag_reg, 6'h00, ctsSync_reg};
          `ADDR_INT_FLAGS: rdData <= intFlags;
          `ADDR_MODE_ONE: rdData <= modeOne_reg;
          `ADDR_CMD: rdData <= {4'h0, rtsBit_reg, rxHunt_reg, txEnable_reg, rxEnable_reg};
          `ADDR_VECTOR: rdData <= vector_reg;
          `ADDR_PIN_LEVEL: rdData <= {7'h00, ctsSync_reg};
          `ADDR_CONFIG: rdData <= {6'h00, config_reg};
          default: rdData <= 8'h00;
        endcase
      end
    end
  end
endmodule // uart_buffers_status
`default_nettype wire

// file: verification/uart_buffers_status_assertions.sv
// port-level checker for the uart buffer and status block
`timescale 1ns/1ps
`default_nettype none
module uart_buffers_status_assertions (
  // clock and reset
  input wire clk,
  input wire rst,
  // register port
  input wire [11:0] addr,
  input wire [7:0] wrData,
  input wire wrStb,
  input wire rdStb,
  input wire [7:0] rdData,
  // shifters, pins, interrupt and baud preload
  input wire txShiftEmpty,
  input wire txLoad,
  input wire rxHunt,
  input wire rxEnabled,
  input wire rtsPinN,
  input wire intReq,
  input wire [7:0] intVector,
  input wire [15:0] baudPreload
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_reset_no_int: assert property ($fell(rst) |-> !intReq)
    else $error("interrupt request high right after reset");
  a_vector_reset_val: assert property ($fell(rst) |-> intVector == 8'h0f)
    else $error("vector not 0x0f after reset");
  a_rts_set_low: assert property (wrStb && addr == 12'h178 && wrData[0] |=> !rtsPinN)
    else $error("rts pin not driven low by set write");
  a_rts_clear_high: assert property (wrStb && addr == 12'h17c && wrData[0] |=> rtsPinN)
    else $error("rts pin not released by clear write");
  a_rts_no_cause: assert property (!(wrStb && (addr == 12'h178 || addr == 12'h17c))
    |=> $stable(rtsPinN))
    else $error("rts pin moved without a port write");
  a_tx_load_pulse: assert property (txLoad |-> $past(txShiftEmpty) ##1 !txLoad)
    else $error("shifter load not a single pulse from an empty shifter");
  a_baud_low_write: assert property (wrStb && addr == 12'h15c |=>
    baudPreload[7:0] == $past(wrData))
    else $error("low preload byte not taken");
  a_read_idle_zero: assert property (!rdStb |=> rdData == 8'h00)
    else $error("read data not zero outside read answer");
  a_rx_disable_hunt: assert property (wrStb && addr == 12'h148 && wrData[1:0] == 2'h2
    |=> !rxHunt || rxEnabled)
    else $error("start bit search kept after disable");
endmodule // uart_buffers_status_assertions
`default_nettype wire

// file: verification/serial_far_end.sv
// transmit shifter stand-in on the serial side, busy for a set time per character
`timescale 1ns/1ps
`default_nettype none
module serial_far_end #(
  parameter BUSY = 30
) (
  // clock
  input wire logic clk,
  // shifter load
  input wire logic txLoad,
  input wire logic [7:0] txChar,
  output logic txShiftEmpty,
  // observed traffic
  output logic [7:0] lastTx,
  output logic [7:0] loads
);
  integer busyCnt = 0;
  logic [7:0] lastTxQ = 8'h00;
  logic [7:0] loadsQ = 8'h00;
  assign lastTx = lastTxQ;
  assign loads = loadsQ;
  assign txShiftEmpty = (busyCnt == 0);
  // a load only while empty, as the shifter would take it
  always @(posedge clk) begin
    if (txLoad && busyCnt == 0) begin
      lastTxQ <= txChar;
      loadsQ <= loadsQ + 8'h01;
      busyCnt <= BUSY;
    end else if (busyCnt != 0) begin
      busyCnt <= busyCnt - 1;
    end
  end
endmodule // serial_far_end
`default_nettype wire

// file: verification/uart_buffers_status_interrupts_tb_top.sv
// register-level testbench for the uart buffer and status block
`timescale 1ns/1ps
`default_nettype none
`include "uart_bsi_regs.vh"
module uart_buffers_status_interrupts_tb_top;
  logic clk = 0, rst = 1, clkEn = 1, wrStb = 0, rdStb = 0;
  logic rxCharDone = 0, rxBreakEdge = 0, serialTick = 0, ctsPinN = 1;
  logic [11:0] addr = 12'h000;
  logic [7:0] wrData = 8'h00, rxChar = 8'h00;
  wire [7:0] rdData, txChar, intVector, lastTx, loads;
  wire [15:0] baudPreload;
  wire rxEnabled, rxHunt, txLoad, txEnabled, txShiftEmpty, rtsPinN, intReq;
  integer errors = 0, total_checks = 0;
  always #2.5 clk = ~clk;
  uart_buffers_status #(.FILTER_CYCLES(4)) uart_buffers_status_inst (.clk(clk), .rst(rst),
    .clkEn(clkEn), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
    .rdData(rdData), .rxCharDone(rxCharDone), .rxChar(rxChar), .rxBreakEdge(rxBreakEdge),
    .rxEnabled(rxEnabled), .rxHunt(rxHunt), .txShiftEmpty(txShiftEmpty), .txLoad(txLoad),
    .txChar(txChar), .txEnabled(txEnabled), .serialTick(serialTick),
    .baudPreload(baudPreload), .ctsPinN(ctsPinN), .rtsPinN(rtsPinN), .intReq(intReq),
    .intVector(intVector));
  serial_far_end serial_far_end_inst (.clk(clk), .txLoad(txLoad), .txChar(txChar),
    .txShiftEmpty(txShiftEmpty), .lastTx(lastTx), .loads(loads));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    wrStb <= 1; addr <= a; wrData <= d;
    @(posedge clk);
    wrStb <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    rdStb <= 1; addr <= a;
    @(posedge clk);
    rdStb <= 0;
    #1 chk({8'h00, rdData & m}, {8'h00, e});
  endtask
  task automatic pulse(input integer k, input logic [7:0] c);
    @(posedge clk);
    if (k == 0) begin rxCharDone <= 1; rxChar <= c; end
    if (k == 1) rxBreakEdge <= 1;
    if (k == 2) serialTick <= 1;
    @(posedge clk);
    rxCharDone <= 0; rxBreakEdge <= 0; serialTick <= 0;
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    end_of_test;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    rd(`ADDR_RX_DATA, 8'hff, 8'hff);
    chk(baudPreload, 16'h0002);
    rd(`ADDR_VECTOR, 8'hff, 8'h0f);
    wr(`ADDR_VECTOR, 8'h5a);
    rd(`ADDR_VECTOR, 8'hff, 8'h5a);
    @(posedge clk) clkEn <= 0;
    wr(`ADDR_VECTOR, 8'h33);
    clkEn <= 1;
    rd(`ADDR_VECTOR, 8'hff, 8'h5a);
    chk(intVector, 8'h5a);
    rd(12'h1f0, 8'hff, 8'h00);
    wr(`ADDR_CMD, 8'h01);
    rd(`ADDR_CMD, 8'h05, 8'h05);
    pulse(0, 8'h11);
    rd(`ADDR_INT_FLAGS, 8'h02, 8'h02);
    wr(`ADDR_MODE_ONE, 8'h40);
    rd(`ADDR_INT_FLAGS, 8'h02, 8'h00);
    pulse(0, 8'h22); pulse(0, 8'h33); pulse(0, 8'h44);
    rd(`ADDR_INT_FLAGS, 8'h02, 8'h02);
    rd(`ADDR_CHANNEL_STATUS, 8'h03, 8'h03);
    rd(`ADDR_RX_DATA, 8'hff, 8'h11);
    rd(`ADDR_RX_DATA, 8'hff, 8'h22);
    rd(`ADDR_RX_DATA, 8'hff, 8'h33);
    rd(`ADDR_CHANNEL_STATUS, 8'h03, 8'h00);
    wr(`ADDR_CMD, 8'h00);
    rd(`ADDR_CMD, 8'h01, 8'h01);
    wr(`ADDR_CMD, 8'h02);
    pulse(0, 8'h55);
    rd(`ADDR_CHANNEL_STATUS, 8'h01, 8'h00);
    wr(`ADDR_CMD, 8'h03);
    rd(`ADDR_CMD, 8'h01, 8'h00);
    wr(`ADDR_CONFIG, 8'h01);
    #1 chk(rxEnabled, 1);
    pulse(0, 8'h66);
    rd(`ADDR_RX_DATA, 8'hff, 8'h66);
    wr(`ADDR_CONFIG, 8'h00);
    wr(`ADDR_CMD, 8'h04);
    #1 chk(txEnabled, 1);
    rd(`ADDR_CHANNEL_STATUS, 8'h04, 8'h04);
    wr(`ADDR_TX_DATA, 8'ha5);
    wr(`ADDR_TX_DATA, 8'h3c);
    rd(`ADDR_CHANNEL_STATUS, 8'h04, 8'h00);
    wr(`ADDR_TX_DATA, 8'h77);
    repeat (80) @(posedge clk);
    #1 chk(loads, 2);
    chk(lastTx, 8'h3c);
    wr(`ADDR_INT_ENABLES, 8'h01);
    #1 chk(intReq, 1);
    rd(`ADDR_INT_FLAGS, 8'h01, 8'h01);
    wr(`ADDR_INT_ENABLES, 8'h00);
    #1 chk(intReq, 0);
    rd(`ADDR_INT_FLAGS, 8'h01, 8'h01);
    wr(`ADDR_CMD, 8'h08);
    #1 chk(txEnabled, 0);
    wr(`ADDR_TX_DATA, 8'h99);
    repeat (40) @(posedge clk);
    #1 chk(loads, 2);
    pulse(1, 8'h00);
    rd(`ADDR_INT_FLAGS, 8'h04, 8'h04);
    wr(`ADDR_CMD, 8'h50);
    rd(`ADDR_INT_FLAGS, 8'h04, 8'h00);
    wr(`ADDR_AUX_CTRL, 8'h01);
    pulse(2, 8'h00); pulse(2, 8'h00);
    rd(`ADDR_IN_CHANGE, 8'h81, 8'h01);
    @(posedge clk) ctsPinN <= 0;
    repeat (20) @(posedge clk);
    rd(`ADDR_INT_FLAGS, 8'h80, 8'h80);
    rd(`ADDR_IN_CHANGE, 8'h81, 8'h80);
    rd(`ADDR_IN_CHANGE, 8'h80, 8'h00);
    rd(`ADDR_INT_FLAGS, 8'h80, 8'h00);
    rd(`ADDR_PIN_LEVEL, 8'h01, 8'h00);
    wr(`ADDR_AUX_CTRL, 8'h00);
    @(posedge clk) ctsPinN <= 1;
    repeat (20) @(posedge clk);
    rd(`ADDR_INT_FLAGS, 8'h80, 8'h00);
    rd(`ADDR_IN_CHANGE, 8'h80, 8'h80);
    rd(`ADDR_PIN_LEVEL, 8'h01, 8'h01);
    wr(`ADDR_OUT_SET, 8'h01);
    #1 chk(rtsPinN, 0);
    wr(`ADDR_OUT_CLEAR, 8'h00);
    #1 chk(rtsPinN, 0);
    wr(`ADDR_OUT_CLEAR, 8'h01);
    #1 chk(rtsPinN, 1);
    wr(`ADDR_BAUD_HIGH, 8'h12);
    wr(`ADDR_BAUD_LOW, 8'h34);
    #1 chk(baudPreload, 16'h1234);
    rd(`ADDR_BAUD_LOW, 8'hff, 8'h00);
    // second reset with the pin asserted across start-up
    @(posedge clk);
    rst <= 1;
    ctsPinN <= 0;
    repeat (2) @(posedge clk);
    rst <= 0;
    pulse(2, 8'h00); pulse(2, 8'h00);
    rd(`ADDR_IN_CHANGE, 8'h81, 8'h80);
    rd(`ADDR_INT_FLAGS, 8'h80, 8'h00);
    end_of_test;
  end
endmodule // uart_buffers_status_interrupts_tb_top
bind uart_buffers_status uart_buffers_status_assertions uart_buffers_status_assertions_inst (
  .clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
  .rdData(rdData), .txShiftEmpty(txShiftEmpty), .txLoad(txLoad), .rxHunt(rxHunt),
  .rxEnabled(rxEnabled),
  .rtsPinN(rtsPinN), .intReq(intReq), .intVector(intVector), .baudPreload(baudPreload));
`default_nettype wire
